// ===== src/irq_agg_pkg.sv
// package: register map, field positions and codes of the analog die irq block
package irq_agg_pkg;
  localparam logic [15:0] BASE_BLOCKING    = 16'h0200;
  localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
  localparam logic [7:0]  OFS_SRC_UPPER    = 8'h08;
  localparam logic [7:0]  OFS_SRC_LOWER    = 8'h09;
  localparam logic [7:0]  OFS_VECTOR       = 8'h0A;
  localparam logic [7:0]  OFS_RESERVED     = 8'h0B;
  localparam logic [7:0]  OFS_MASK_UPPER   = 8'h0C;
  localparam logic [7:0]  OFS_MASK_LOWER   = 8'h0D;
  localparam logic [7:0]  MASK_UPPER_RST   = 8'h00;
  localparam logic [7:0]  MASK_LOWER_RST   = 8'h00;
  localparam logic [7:0]  LOWER_USED_BITS  = 8'h3F;
  localparam logic [7:0]  VECTOR_NONE      = 8'h00;
  localparam logic [7:0]  VECTOR_FIRST     = 8'h01;
  localparam logic [7:0]  VECTOR_LAST      = 8'h0E;
  localparam int          NUM_SOURCES      = 14;
  // source index in priority order, index 0 highest
  localparam int SRC_UNDERVOLTAGE = 0;
  localparam int SRC_HIGH_TEMP    = 1;
  localparam int SRC_LIN_OVERTEMP = 2;
  localparam int SRC_TIMER_CHAN0  = 3;
  localparam int SRC_TIMER_OVF    = 7;
  localparam int SRC_SERIAL_ERR   = 8;
  localparam int SRC_SERIAL_TX    = 9;
  localparam int SRC_SERIAL_RX    = 10;
  localparam int SRC_MEAS_DONE    = 11;
  localparam int SRC_LIFETIME     = 12;
  localparam int SRC_RECAL        = 13;
endpackage

// ===== src/irq_aggregator.sv
// analog die interrupt aggregator with mirror, vector and per-source mask
`timescale 1ns/10ps
module irq_aggregator (
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_UNDERVOLTAGE,
  input  wire logic        I_CRANK_WAKEUP,
  input  wire logic        I_HIGH_TEMP,
  input  wire logic        I_LIN_OVERTEMP,
  input  wire logic [3:0]  I_TIMER_CHAN,
  input  wire logic        I_TIMER_OVERFLOW,
  input  wire logic        I_SERIAL_ERROR,
  input  wire logic        I_SERIAL_TRANSMIT,
  input  wire logic        I_SERIAL_RECEIVE,
  input  wire logic        I_VOLTAGE_DONE_FLAG,
  input  wire logic        I_CURRENT_DONE_FLAG,
  input  wire logic        I_LIFETIME_OVERFLOW,
  input  wire logic        I_LIFETIME_IRQ_ENABLE,
  input  wire logic        I_RECAL_REQUEST,
  input  wire logic        I_SEL,
  input  wire logic        I_WRITE,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  output logic      [7:0]  O_RDATA,
  output logic             O_ACK,
  output logic             O_DIE_LINK_IRQ_LINE
);

  typedef struct packed {
    logic [7:0] mask_upper;
    logic [7:0] mask_lower;
    logic [7:0] rdata;
    logic       ack;
    logic       irq;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic [13:0] pending;
  logic [7:0]  src_upper;
  logic [7:0]  src_lower;
  logic [7:0]  vector;
  logic [7:0]  offset;
  logic        hit;

  // lowest set index wins, it carries the highest priority
  function automatic logic [7:0] encode_priority(input logic [13:0] p);
    logic [7:0] code;
    code = irq_agg_pkg::VECTOR_NONE;
    for (int i = irq_agg_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
      if (p[i]) begin
        code = 8'(i) + irq_agg_pkg::VECTOR_FIRST;
      end
    end
    return code;
  endfunction

  // decodes a global address into a local offset and a hit flag
  function automatic logic [8:0] decode_addr(input logic [15:0] a);
    logic [8:0] r;
    r = 9'h000;
    if (a[15:8] == irq_agg_pkg::BASE_BLOCKING[15:8] ||
        a[15:8] == irq_agg_pkg::BASE_NONBLOCKING[15:8]) begin
      r = {1'b1, a[7:0]};
    end
    return r;
  endfunction

  always_comb begin
    pending = '0;
    pending[irq_agg_pkg::SRC_UNDERVOLTAGE] = I_UNDERVOLTAGE | I_CRANK_WAKEUP;
    pending[irq_agg_pkg::SRC_HIGH_TEMP]    = I_HIGH_TEMP;
    pending[irq_agg_pkg::SRC_LIN_OVERTEMP] = I_LIN_OVERTEMP;
    pending[irq_agg_pkg::SRC_TIMER_CHAN0 +: 4] = I_TIMER_CHAN;
    pending[irq_agg_pkg::SRC_TIMER_OVF]    = I_TIMER_OVERFLOW;
    pending[irq_agg_pkg::SRC_SERIAL_ERR]   = I_SERIAL_ERROR;
    pending[irq_agg_pkg::SRC_SERIAL_TX]    = I_SERIAL_TRANSMIT;
    pending[irq_agg_pkg::SRC_SERIAL_RX]    = I_SERIAL_RECEIVE;
    pending[irq_agg_pkg::SRC_MEAS_DONE]    =
      I_VOLTAGE_DONE_FLAG | I_CURRENT_DONE_FLAG;
    pending[irq_agg_pkg::SRC_LIFETIME]     =
      I_LIFETIME_OVERFLOW & I_LIFETIME_IRQ_ENABLE;
    pending[irq_agg_pkg::SRC_RECAL]        = I_RECAL_REQUEST;
  end

  // sources map straight onto mirror bits in priority order
  assign src_upper = pending[7:0];
  assign src_lower = {2'b00, pending[13:8]};
  assign vector    = encode_priority(pending);
  assign {hit, offset} = decode_addr(I_ADDR);

  always_comb begin
    state_nxt     = state_r;
    state_nxt.ack = I_SEL;
    state_nxt.rdata = 8'h00;
    if (I_SEL && hit && I_WRITE) begin
      // mirror, vector and reserved slot are read-only; writes drop
      if (offset == irq_agg_pkg::OFS_MASK_UPPER) begin
        state_nxt.mask_upper = I_WDATA;
      end
      if (offset == irq_agg_pkg::OFS_MASK_LOWER) begin
        state_nxt.mask_lower = I_WDATA & irq_agg_pkg::LOWER_USED_BITS;
      end
    end
    if (I_SEL && hit && !I_WRITE) begin
      // reads have no side effect on any source
      unique case (offset)
        irq_agg_pkg::OFS_SRC_UPPER:  state_nxt.rdata = src_upper;
        irq_agg_pkg::OFS_SRC_LOWER:  state_nxt.rdata = src_lower;
        irq_agg_pkg::OFS_VECTOR:     state_nxt.rdata = vector;
        irq_agg_pkg::OFS_RESERVED:   state_nxt.rdata = 8'h00;
        irq_agg_pkg::OFS_MASK_UPPER: state_nxt.rdata = state_r.mask_upper;
        irq_agg_pkg::OFS_MASK_LOWER: state_nxt.rdata = state_r.mask_lower;
        default:                     state_nxt.rdata = 8'h00;
      endcase
    end
    state_nxt.irq = |(pending & ~{state_r.mask_lower[5:0],
                                  state_r.mask_upper});
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r.mask_upper <= irq_agg_pkg::MASK_UPPER_RST;
      state_r.mask_lower <= irq_agg_pkg::MASK_LOWER_RST;
      state_r.rdata      <= 8'h00;
      state_r.ack        <= 1'b0;
      state_r.irq        <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign O_RDATA             = state_r.rdata;
  assign O_ACK               = state_r.ack;
  assign O_DIE_LINK_IRQ_LINE = state_r.irq;

  property p_irq_follows;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (|(pending & ~{state_r.mask_lower[5:0], state_r.mask_upper}))
      |=> O_DIE_LINK_IRQ_LINE;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq line not raised for unmasked pending source");

  property p_irq_quiet;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      !(|(pending & ~{state_r.mask_lower[5:0], state_r.mask_upper}))
      |=> !O_DIE_LINK_IRQ_LINE;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("irq line raised with nothing enabled pending");

  property p_vector_read;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_SEL && !I_WRITE && hit && offset == irq_agg_pkg::OFS_VECTOR &&
       pending == 14'h0000) |=> (O_RDATA == irq_agg_pkg::VECTOR_NONE);
  endproperty
  a_vector_read: assert property (p_vector_read)
    else $error("vector not zero with nothing pending");

  property p_vector_top;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_SEL && !I_WRITE && hit && offset == irq_agg_pkg::OFS_VECTOR &&
       pending[irq_agg_pkg::SRC_UNDERVOLTAGE])
      |=> (O_RDATA == irq_agg_pkg::VECTOR_FIRST);
  endproperty
  a_vector_top: assert property (p_vector_top)
    else $error("undervoltage not reported as top vector");

  property p_vector_last;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_SEL && !I_WRITE && hit && offset == irq_agg_pkg::OFS_VECTOR &&
       pending == 14'h2000) |=> (O_RDATA == irq_agg_pkg::VECTOR_LAST);
  endproperty
  a_vector_last: assert property (p_vector_last)
    else $error("recal only pending gives wrong vector");

  property p_lower_top_zero;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_SEL && !I_WRITE && hit && offset == irq_agg_pkg::OFS_SRC_LOWER)
      |=> (O_RDATA[7:6] == 2'b00 && O_RDATA[5] == $past(I_RECAL_REQUEST));
  endproperty
  a_lower_top_zero: assert property (p_lower_top_zero)
    else $error("lower mirror top bits wrong");

  property p_reserved_zero;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_SEL && hit && offset == irq_agg_pkg::OFS_RESERVED)
      |=> (O_RDATA == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved slot read not zero");

  property p_mask_write;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_SEL && I_WRITE && hit && offset == irq_agg_pkg::OFS_MASK_UPPER)
      |=> (state_r.mask_upper == $past(I_WDATA));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("upper mask not written");

  property p_meas_source;
    @(posedge I_CLOCK) disable iff (!I_ARST_N)
      (I_VOLTAGE_DONE_FLAG || I_CURRENT_DONE_FLAG)
      |-> pending[irq_agg_pkg::SRC_MEAS_DONE];
  endproperty
  a_meas_source: assert property (p_meas_source)
    else $error("measurement source not raised");

endmodule

// ===== tb/irq_aggregator_tb_top.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/10ps
module irq_aggregator_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [13:0] src = 14'h0000;
  logic        crank = 1'b0;
  logic        cur_done = 1'b0;
  logic        lt_en = 1'b1;
  logic        sel, wr, ack, irq;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, q;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  irq_aggregator dut (.I_CLOCK(clk), .I_ARST_N(arst_n),
    .I_UNDERVOLTAGE(src[0]), .I_CRANK_WAKEUP(crank), .I_HIGH_TEMP(src[1]),
    .I_LIN_OVERTEMP(src[2]), .I_TIMER_CHAN(src[6:3]),
    .I_TIMER_OVERFLOW(src[7]), .I_SERIAL_ERROR(src[8]),
    .I_SERIAL_TRANSMIT(src[9]), .I_SERIAL_RECEIVE(src[10]),
    .I_VOLTAGE_DONE_FLAG(src[11]), .I_CURRENT_DONE_FLAG(cur_done),
    .I_LIFETIME_OVERFLOW(src[12]), .I_LIFETIME_IRQ_ENABLE(lt_en),
    .I_RECAL_REQUEST(src[13]), .I_SEL(sel), .I_WRITE(wr), .I_ADDR(addr),
    .I_WDATA(wdata), .O_RDATA(rdata), .O_ACK(ack),
    .O_DIE_LINK_IRQ_LINE(irq));
  mcu_model mcu (.i_clock(clk), .i_ack(ack), .i_rdata(rdata), .o_sel(sel),
    .o_write(wr), .o_addr(addr), .o_wdata(wdata));
  task automatic check(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, string w);
    mcu.access(1'b0, a, 8'h00, q);
    check(w, q, e);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    mcu.access(1'b1, a, d, q);
    check("write_answer", q, 8'h00);
  endtask
  task automatic irq_is(input logic e);
    // the request line follows the mask one cycle after the write answer
    repeat (2) @(posedge clk);
    #1 check("irq_line", {7'h00, irq}, {7'h00, e});
  endtask
  task automatic t_reset;
    rd(16'h020C, 8'h00, "mask_upper_reset");
    rd(16'h030D, 8'h00, "mask_lower_reset");
    check("irq_reset", {7'h00, irq}, 8'h00);
  endtask
  task automatic t_priority;
    logic [13:0] s;
    for (int i = 0; i < 14; i++) begin
      // this source plus every lower-priority one pending
      s = 14'h3FFF << i;
      @(posedge clk);
      src <= s;
      rd(16'h0208, s[7:0], "src_upper");
      rd(16'h0309, {2'b00, s[13:8]}, "src_lower");
      rd(16'h020A, 8'(i + 1), "vector");
    end
    @(posedge clk);
    src <= 14'h0000;
    rd(16'h020A, 8'h00, "vector_none");
  endtask
  task automatic t_alt;
    @(posedge clk);
    crank <= 1'b1;
    rd(16'h0208, 8'h01, "crank_upper");
    rd(16'h020A, 8'h01, "crank_vector_again");
    rd(16'h0208, 8'h01, "crank_upper_again");
    crank <= 1'b0;
    cur_done <= 1'b1;
    rd(16'h0209, 8'h08, "current_done");
    cur_done <= 1'b0;
    lt_en <= 1'b0;
    src <= 14'h1000;
    rd(16'h0209, 8'h00, "lifetime_disabled");
    lt_en <= 1'b1;
    rd(16'h0309, 8'h10, "lifetime_enabled");
  endtask
  task automatic t_mask;
    @(posedge clk);
    src <= 14'h0100;
    wr_reg(16'h030C, 8'hFF);
    wr_reg(16'h020D, 8'hFF);
    rd(16'h020C, 8'hFF, "mask_upper");
    rd(16'h030D, 8'h3F, "mask_lower");
    wr_reg(16'h020D, 8'h01);
    irq_is(1'b0);
    wr_reg(16'h030D, 8'h3E);
    irq_is(1'b1);
    wr_reg(16'h020B, 8'hFF);
    rd(16'h020B, 8'h00, "reserved");
    rd(16'h0408, 8'h00, "base_miss");
    // only undervoltage pending: the upper mask alone decides the line
    @(posedge clk);
    src <= 14'h0001;
    wr_reg(16'h020C, 8'h01);
    irq_is(1'b0);
    wr_reg(16'h030C, 8'hFE);
    irq_is(1'b1);
  endtask
  task automatic conclude;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_priority();
    t_alt();
    t_mask();
    conclude();
  end
endmodule

// ===== tb/mcu_model.sv
// microcontroller side model issuing register accesses
`timescale 1ns/10ps
module mcu_model (
  input  wire logic        i_clock,
  input  wire logic        i_ack,
  input  wire logic [7:0]  i_rdata,
  output logic             o_sel,
  output logic             o_write,
  output logic [15:0]      o_addr,
  output logic [7:0]       o_wdata
);
  initial begin
    o_sel = 1'b0;
    o_write = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 8'h00;
  end
  // one strobe cycle; the answer is taken one edge after the taking edge
  task automatic access(input logic wr, input logic [15:0] adr,
                        input logic [7:0] dat, output logic [7:0] q);
    @(posedge i_clock);
    o_sel <= 1'b1;
    o_write <= wr;
    o_addr <= adr;
    o_wdata <= dat;
    @(posedge i_clock);
    o_sel <= 1'b0;
    // released lines flip so that no stale value can be mistaken for data
    o_addr <= ~adr;
    o_wdata <= ~dat;
    // the answer stands in the cycle after the taking edge; take it at the
    // closing edge, before the design's registers move on
    @(posedge i_clock);
    q = (i_ack === 1'b1) ? i_rdata : 8'hXX;
  endtask
endmodule
